// File: src/tccc_axil.sv
// AXI4-Lite slave front end for the register file
`timescale 1ns/10ps
`default_nettype none
module tccc_axil
	import tccc_pkg::*;
(
	// Clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// Write channels
	input  wire logic [AXI_ADDR_W-1:0] awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic      [1:0]            bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	// Read channels
	input  wire logic [AXI_ADDR_W-1:0] araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic      [31:0]           rdata,
	output logic      [1:0]            rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	// Core side
	tccc_reg_if.bus                    rg
);
	typedef struct packed {
		logic             aw_got;
		logic [IDX_W-1:0] aw_idx;
		logic             aw_bad;
		logic             w_got;
		logic [7:0]       w_data;
		logic             w_lane;
		logic             awready;
		logic             wready;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             arready;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
	} tccc_axs_t;
	tccc_axs_t st_r, st_nxt;
	logic ar_bad;
	assign ar_bad     = araddr[AXI_ADDR_W-1:IDX_W+2] != '0;
	assign rg.rd_idx  = araddr[IDX_W+1:2];
	assign rg.rd_en   = arvalid & st_r.arready & ~ar_bad;
	assign rg.wr_idx  = st_r.aw_idx;
	assign rg.wr_data = st_r.w_data;
	assign rg.wr_en   = st_r.aw_got & st_r.w_got & ~st_r.aw_bad & st_r.w_lane;
	always_comb begin
		st_nxt = st_r;
		if (awvalid && st_r.awready) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.aw_idx = awaddr[IDX_W+1:2];
			st_nxt.aw_bad = awaddr[AXI_ADDR_W-1:IDX_W+2] != '0;
		end
		if (wvalid && st_r.wready) begin
			st_nxt.w_got  = 1'b1;
			st_nxt.w_data = wdata[7:0];
			st_nxt.w_lane = wstrb[0];
		end
		if (st_r.bvalid && bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_r.aw_got && st_r.w_got) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got  = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp  = st_r.aw_bad ? RESP_SLVERR : RESP_OKAY;
		end
		if (st_r.rvalid && rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (arvalid && st_r.arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata  = ar_bad ? 32'h0 : {24'h0, rg.rd_data};
			st_nxt.rresp  = ar_bad ? RESP_SLVERR : RESP_OKAY;
		end
		st_nxt.awready = ~st_nxt.aw_got & ~st_nxt.bvalid;
		st_nxt.wready  = ~st_nxt.w_got & ~st_nxt.bvalid;
		st_nxt.arready = ~st_nxt.rvalid;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign awready = st_r.awready;
	assign wready  = st_r.wready;
	assign bvalid  = st_r.bvalid;
	assign bresp   = st_r.bresp;
	assign arready = st_r.arready;
	assign rvalid  = st_r.rvalid;
	assign rdata   = st_r.rdata;
	assign rresp   = st_r.rresp;
endmodule : tccc_axil
`default_nettype wire

// File: src/tccc_pkg.sv
// Shared constants of the timer channel compare control block
package tccc_pkg;
	localparam int unsigned REG_W      = 8;
	localparam int unsigned IDX_W      = 4;
	localparam int unsigned AXI_ADDR_W = 8;
	localparam logic [3:0]  IDX_MODE_SEL = 4'h0;
	localparam logic [3:0]  IDX_FORCE    = 4'h1;
	localparam logic [3:0]  IDX_OVR_MASK = 4'h2;
	localparam logic [3:0]  IDX_OVR_DATA = 4'h3;
	localparam logic [3:0]  IDX_CNT_HI   = 4'h4;
	localparam logic [3:0]  IDX_CNT_LO   = 4'h5;
	localparam logic [3:0]  IDX_SYSCTL1  = 4'h6;
	localparam logic [3:0]  IDX_TOG_OVF  = 4'h7;
	localparam logic [3:0]  IDX_ACT_HI   = 4'h8;
	localparam logic [3:0]  IDX_ACT_LO   = 4'h9;
	localparam logic [3:0]  IDX_EDGE_HI  = 4'ha;
	localparam logic [3:0]  IDX_EDGE_LO  = 4'hb;
	localparam logic [3:0]  IDX_IRQ_EN   = 4'hc;
	localparam logic [3:0]  IDX_SYSCTL2  = 4'hd;
	localparam logic [3:0]  IDX_CH_FLAGS = 4'he;
	localparam logic [3:0]  IDX_OVF_FLAG = 4'hf;
	localparam logic [7:0]  CH_MASK      = 8'hfc;
	localparam logic [7:0]  LO_PAIR_MASK = 8'hf0;
	localparam logic [7:0]  SC1_MASK     = 8'hf0;
	localparam logic [7:0]  SC2_MASK     = 8'h8f;
	localparam logic [7:0]  RST_VAL      = 8'h00;
	localparam int unsigned RUN_EN_BIT   = 7;
	localparam int unsigned HALT_WAIT_BIT = 6;
	localparam int unsigned HALT_FRZ_BIT = 5;
	localparam int unsigned FAST_CLR_BIT = 4;
	localparam int unsigned OVF_IRQ_BIT  = 7;
	localparam int unsigned CNT_RST_BIT  = 3;
	localparam int unsigned OVF_FLAG_BIT = 7;
	localparam logic [1:0]  ACT_TOGGLE   = 2'h1;
	localparam logic [1:0]  ACT_CLEAR    = 2'h2;
	localparam logic [1:0]  ACT_SET      = 2'h3;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage : tccc_pkg

// File: src/tccc_reg_if.sv
// Register access carrier between bus slave and core
`timescale 1ns/10ps
`default_nettype none
interface tccc_reg_if;
	import tccc_pkg::*;
	logic             wr_en;
	logic [IDX_W-1:0] wr_idx;
	logic [REG_W-1:0] wr_data;
	logic             rd_en;
	logic [IDX_W-1:0] rd_idx;
	logic [REG_W-1:0] rd_data;
	modport bus  (output wr_en, wr_idx, wr_data, rd_en, rd_idx, input rd_data);
	modport core (input wr_en, wr_idx, wr_data, rd_en, rd_idx, output rd_data);
endinterface : tccc_reg_if
`default_nettype wire

// File: src/tccc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module tccc_sync #(
	parameter int unsigned W = 8
) (
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} tccc_sync_t;
	tccc_sync_t st_r, st_nxt;
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.q  = (~(st_r.s2 ^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.q);
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign q = st_r.q;
endmodule : tccc_sync
`default_nettype wire

// File: src/tccc_top.sv
// Timer channel mode, force and channel 7 override logic
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Channel 7 pin serves capture/compare and also feeds the pulse accumulator
// - Mode bit 0 means input capture, 1 means output compare, channels 7..2
// - Force register always reads back as zero
// - Force bit runs the programmed compare pin action without setting the flag
// - Force and real match together: forced action applied, flag stays clear
// - Channel 7 compare beats channels 6..2 on pins it controls
// - Mask bit makes pin an output when that channel is in compare mode
// - Channel 7 compare drives each masked compare-mode pin to its override data bit
// - Registers decode at base plus fixed offset, counter split in two bytes
// - Run enable low halts the counter; high lets it run except in wait or freeze with that halt bit set
// - Override data supplies pin levels for masked pins on channel 7 compare
module tccc_top
	import tccc_pkg::*;
(
	// Clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// AXI4-Lite write
	input  wire logic [AXI_ADDR_W-1:0] awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic      [1:0]            bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	// AXI4-Lite read
	input  wire logic [AXI_ADDR_W-1:0] araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic      [31:0]           rdata,
	output logic      [1:0]            rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	// Timer pins
	input  wire logic                  ch7_timer_pin_in,
	input  wire logic                  ch6_timer_pin_in,
	input  wire logic                  ch5_timer_pin_in,
	input  wire logic                  ch4_timer_pin_in,
	input  wire logic                  ch3_timer_pin_in,
	input  wire logic                  ch2_timer_pin_in,
	output logic                       ch7_timer_pin_out,
	output logic                       ch6_timer_pin_out,
	output logic                       ch5_timer_pin_out,
	output logic                       ch4_timer_pin_out,
	output logic                       ch3_timer_pin_out,
	output logic                       ch2_timer_pin_out,
	output logic                       ch7_timer_pin_oe,
	output logic                       ch6_timer_pin_oe,
	output logic                       ch5_timer_pin_oe,
	output logic                       ch4_timer_pin_oe,
	output logic                       ch3_timer_pin_oe,
	output logic                       ch2_timer_pin_oe,
	// Compare logic and chip modes
	input  wire logic [7:2]            cmp_match,
	input  wire logic                  mcu_wait,
	input  wire logic                  mcu_freeze,
	output logic      [15:0]           main_counter,
	output logic                       pulse_acc_in,
	output logic                       irq
);
	typedef struct packed {
		logic [7:0]  mode;
		logic [7:0]  mask;
		logic [7:0]  data;
		logic [15:0] cnt;
		logic [7:0]  sc1;
		logic [7:0]  tog;
		logic [15:0] act;
		logic [15:0] edg;
		logic [7:0]  ie;
		logic [7:0]  sc2;
		logic [7:0]  flags;
		logic        ovf;
		logic [7:0]  pin;
		logic [7:0]  oe;
		logic [7:0]  prev;
		logic        pa;
		logic        irq;
	} tccc_core_t;

	tccc_core_t  st_r, st_nxt;
	tccc_reg_if  rg ();
	logic [7:0]  pin_raw;
	logic [7:0]  pin_s;
	logic [7:0]  force_w;
	logic [7:0]  match_w;
	logic [7:0]  rd_w;
	logic        cnt_en;
	logic        ch7_evt;
	logic        ovf_evt;
	logic        cnt_rst;
	logic [7:0]  fm_w;
	logic [7:0]  mo_w;
	logic [7:0]  ovr_w;

	tccc_axil u_axil (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.rg      (rg.bus)
	);

	assign pin_raw = {ch7_timer_pin_in, ch6_timer_pin_in, ch5_timer_pin_in,
		ch4_timer_pin_in, ch3_timer_pin_in, ch2_timer_pin_in, 2'b00};

	tccc_sync #(
		.W (8)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (pin_raw),
		.q       (pin_s)
	);

	function automatic logic hit(input logic en, input logic [3:0] a, input logic [3:0] b);
		return en && (a == b);
	endfunction : hit

	function automatic logic act_apply(input logic [1:0] c, input logic p);
		case (c)
			ACT_TOGGLE: return ~p;
			ACT_CLEAR:  return 1'b0;
			ACT_SET:    return 1'b1;
			default:    return p;
		endcase
	endfunction : act_apply

	assign match_w = {cmp_match, 2'b00};
	assign force_w = hit(rg.wr_en, rg.wr_idx, IDX_FORCE) ? (rg.wr_data & CH_MASK) : 8'h00;
	assign cnt_en  = st_r.sc1[RUN_EN_BIT] & ~(mcu_wait & st_r.sc1[HALT_WAIT_BIT])
		& ~(mcu_freeze & st_r.sc1[HALT_FRZ_BIT]);
	assign ch7_evt = st_r.mode[7] & (match_w[7] | force_w[7]);
	assign cnt_rst = cnt_en & st_r.sc2[CNT_RST_BIT] & st_r.mode[7] & match_w[7];
	assign ovf_evt = cnt_en & ~cnt_rst & (st_r.cnt == 16'hffff);

	always_comb begin
		logic [7:0] set_f;
		logic [7:0] clr_f;
		logic       rise;
		logic       fall;
		logic [1:0] ec;
		logic       v;
		set_f  = 8'h00;
		clr_f  = 8'h00;
		rise   = 1'b0;
		fall   = 1'b0;
		ec     = 2'h0;
		v      = 1'b0;
		st_nxt = st_r;
		if (rg.wr_en) begin
			case (rg.wr_idx)
				IDX_MODE_SEL: st_nxt.mode = rg.wr_data & CH_MASK;
				IDX_OVR_MASK: st_nxt.mask = rg.wr_data & CH_MASK;
				IDX_OVR_DATA: st_nxt.data = rg.wr_data & CH_MASK;
				IDX_SYSCTL1:  st_nxt.sc1 = rg.wr_data & SC1_MASK;
				IDX_TOG_OVF:  st_nxt.tog = rg.wr_data & CH_MASK;
				IDX_ACT_HI:   st_nxt.act[15:8] = rg.wr_data;
				IDX_ACT_LO:   st_nxt.act[7:0] = rg.wr_data & LO_PAIR_MASK;
				IDX_EDGE_HI:  st_nxt.edg[15:8] = rg.wr_data;
				IDX_EDGE_LO:  st_nxt.edg[7:0] = rg.wr_data & LO_PAIR_MASK;
				IDX_IRQ_EN:   st_nxt.ie = rg.wr_data;
				IDX_SYSCTL2:  st_nxt.sc2 = rg.wr_data & SC2_MASK;
				IDX_CH_FLAGS: clr_f = rg.wr_data & CH_MASK;
				default:      ;
			endcase
		end
		// Counter
		if (cnt_rst) begin
			st_nxt.cnt = 16'h0000;
		end else if (cnt_en) begin
			st_nxt.cnt = st_r.cnt + 16'h0001;
		end
		// Per-channel pin action and flags
		st_nxt.prev = pin_s;
		for (int i = 2; i < 8; i++) begin
			ec   = st_r.edg[2*i+1 -: 2];
			rise = pin_s[i] & ~st_r.prev[i];
			fall = ~pin_s[i] & st_r.prev[i];
			v    = st_r.pin[i];
			if (st_r.mode[i]) begin
				if (ovf_evt && st_r.tog[i]) begin
					v = ~st_r.pin[i];
				end else if (match_w[i] || force_w[i]) begin
					v = act_apply(st_r.act[2*i+1 -: 2], st_r.pin[i]);
				end
				if (ch7_evt && st_r.mask[i]) begin
					v = st_r.data[i];
				end
				set_f[i] = match_w[i] & ~force_w[i];
			end else begin
				set_f[i] = (ec[0] & rise) | (ec[1] & fall);
			end
			st_nxt.pin[i] = v;
		end
		st_nxt.oe = st_nxt.mode & (st_nxt.mask | st_nxt.tog
			| {|st_nxt.act[15:14], |st_nxt.act[13:12], |st_nxt.act[11:10],
			|st_nxt.act[9:8], |st_nxt.act[7:6], |st_nxt.act[5:4], 2'b00});
		st_nxt.flags = (st_r.flags & ~clr_f) | set_f;
		// Overflow flag, set wins over any clear
		if (ovf_evt) begin
			st_nxt.ovf = 1'b1;
		end else if ((hit(rg.wr_en, rg.wr_idx, IDX_OVF_FLAG) && rg.wr_data[OVF_FLAG_BIT])
			|| (st_r.sc1[FAST_CLR_BIT] && (hit(rg.wr_en, rg.wr_idx, IDX_CNT_HI)
			|| hit(rg.wr_en, rg.wr_idx, IDX_CNT_LO) || hit(rg.rd_en, rg.rd_idx, IDX_CNT_HI)
			|| hit(rg.rd_en, rg.rd_idx, IDX_CNT_LO)))) begin
			st_nxt.ovf = 1'b0;
		end
		st_nxt.pa  = pin_s[7];
		st_nxt.irq = (|(st_nxt.flags & st_nxt.ie & CH_MASK)) | (st_nxt.ovf & st_nxt.sc2[OVF_IRQ_BIT]);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Register read mux
	always_comb begin
		rd_w = RST_VAL;
		case (rg.rd_idx)
			IDX_MODE_SEL: rd_w = st_r.mode;
			IDX_FORCE:    rd_w = 8'h00;
			IDX_OVR_MASK: rd_w = st_r.mask;
			IDX_OVR_DATA: rd_w = st_r.data;
			IDX_CNT_HI:   rd_w = st_r.cnt[15:8];
			IDX_CNT_LO:   rd_w = st_r.cnt[7:0];
			IDX_SYSCTL1:  rd_w = st_r.sc1;
			IDX_TOG_OVF:  rd_w = st_r.tog;
			IDX_ACT_HI:   rd_w = st_r.act[15:8];
			IDX_ACT_LO:   rd_w = st_r.act[7:0];
			IDX_EDGE_HI:  rd_w = st_r.edg[15:8];
			IDX_EDGE_LO:  rd_w = st_r.edg[7:0];
			IDX_IRQ_EN:   rd_w = st_r.ie;
			IDX_SYSCTL2:  rd_w = st_r.sc2;
			IDX_CH_FLAGS: rd_w = st_r.flags;
			IDX_OVF_FLAG: rd_w = {st_r.ovf, 7'h00};
			default:      rd_w = RST_VAL;
		endcase
	end
	assign rg.rd_data = rd_w;

	assign ch7_timer_pin_out = st_r.pin[7];
	assign ch6_timer_pin_out = st_r.pin[6];
	assign ch5_timer_pin_out = st_r.pin[5];
	assign ch4_timer_pin_out = st_r.pin[4];
	assign ch3_timer_pin_out = st_r.pin[3];
	assign ch2_timer_pin_out = st_r.pin[2];
	assign ch7_timer_pin_oe  = st_r.oe[7];
	assign ch6_timer_pin_oe  = st_r.oe[6];
	assign ch5_timer_pin_oe  = st_r.oe[5];
	assign ch4_timer_pin_oe  = st_r.oe[4];
	assign ch3_timer_pin_oe  = st_r.oe[3];
	assign ch2_timer_pin_oe  = st_r.oe[2];
	assign main_counter      = st_r.cnt;
	assign pulse_acc_in      = st_r.pa;
	assign irq               = st_r.irq;

	// Checks
	assign fm_w  = force_w & match_w & st_r.mode & ~st_r.flags;
	assign mo_w  = match_w & ~force_w & st_r.mode;
	assign ovr_w = {8{ch7_evt}} & st_r.mode & st_r.mask;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_force_on_match;
		(|fm_w);
	endsequence

	sequence s_match_alone;
		(|mo_w);
	endsequence

	sequence s_ovr7;
		(|ovr_w);
	endsequence

	sequence s_ch7_hits_ch6;
		ch7_evt && st_r.mode[6] && st_r.mask[6];
	endsequence

	a_force_reads_zero: assert property (rg.rd_en && rg.rd_idx == IDX_FORCE |=> rdata == 32'h00000000)
		else $error("force register read not zero");
	a_force_no_flag: assert property (s_force_on_match |=> (st_r.flags & $past(fm_w)) == 8'h00)
		else $error("forced compare set the channel flag");
	a_ch7_override_pin: assert property (s_ch7_hits_ch6 |=> st_r.pin[6] == $past(st_r.data[6]))
		else $error("channel 7 override did not drive pin 6");
	a_capture_no_drive: assert property ((st_r.oe & ~st_r.mode) == 8'h00)
		else $error("capture channel drives its pin");
	a_mask_makes_out: assert property ((st_r.mode & st_r.mask & ~st_r.oe) == 8'h00)
		else $error("masked compare channel not driving");
	a_counter_halt: assert property (!st_r.sc1[RUN_EN_BIT] |=> $stable(st_r.cnt))
		else $error("counter moved while disabled");
	a_counter_step: assert property (cnt_en && !cnt_rst |=> st_r.cnt == $past(st_r.cnt) + 16'h0001)
		else $error("counter did not advance");
	a_data_decode: assert property (rg.wr_en && rg.wr_idx == IDX_OVR_DATA
		|=> st_r.data == ($past(rg.wr_data) & CH_MASK))
		else $error("override data write not stored");
	a_unimpl_bits: assert property (((st_r.mode | st_r.mask | st_r.data | st_r.flags) & ~CH_MASK) == 8'h00)
		else $error("unimplemented bits set");
	a_pa_follows_pin: assert property ($changed(pin_s[7]) |=> pulse_acc_in == $past(pin_s[7]))
		else $error("accumulator input lags channel 7 pin");
	a_match_sets_flag: assert property (s_match_alone |=> (st_r.flags & $past(mo_w)) == $past(mo_w))
		else $error("compare match did not set the channel flag");
	a_ch7_override_all: assert property (s_ovr7 |=>
		(st_r.pin & $past(ovr_w)) == ($past(st_r.data) & $past(ovr_w)))
		else $error("channel 7 override missed a masked pin");
	a_irq_level: assert property (irq == ((|(st_r.flags & st_r.ie & CH_MASK))
		| (st_r.ovf & st_r.sc2[OVF_IRQ_BIT])))
		else $error("interrupt output disagrees with flags");
	a_ovf_set_wins: assert property (ovf_evt |=> st_r.ovf)
		else $error("overflow flag not set on wrap");
	a_counter_clear: assert property (cnt_rst |=> st_r.cnt == 16'h0000)
		else $error("counter not cleared on channel 7 match");
	a_capture_pin_hold: assert property (st_r.mode == 8'h00 |=> $stable(st_r.pin))
		else $error("capture channel pin level moved");
endmodule : tccc_top
`default_nettype wire

// File: verification/tccc_pin_model.sv
// Model of the outside world on the six timer channel pins
`timescale 1ns/10ps
`default_nettype none
module tccc_pin_model (
	// Clock
	input  wire logic       aclk,
	// Block side
	input  wire logic [7:2] pin_out,
	input  wire logic [7:2] pin_oe,
	// Bench side
	input  wire logic [7:2] ext_en,
	input  wire logic [7:2] ext_val,
	// Resolved pin level
	output logic      [7:2] pin_in
);
	logic [7:2] float_r = 6'h00;

	// Undriven pins wander, never a steady level
	always_ff @(posedge aclk) begin
		float_r <= ~float_r;
	end

	// Block drive wins, then the outside source
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & float_r);
endmodule : tccc_pin_model
`default_nettype wire

// File: verification/tccc_tb_top.sv
// Self-checking bench for the timer channel compare control block
`timescale 1ns/10ps
`default_nettype none
module tccc_tb_top;
	import tccc_pkg::*;
	typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] r; logic [1:0] s;} tccc_row_t;
	localparam tccc_row_t ROWS [9] = '{'{8'h00, 8'hff, 8'hfc, RESP_OKAY}, '{8'h04, 8'hfc, 8'h00, RESP_OKAY},
		'{8'h08, 8'hff, 8'hfc, RESP_OKAY}, '{8'h0c, 8'hab, 8'ha8, RESP_OKAY}, '{8'h1c, 8'h03, 8'h00, RESP_OKAY},
		'{8'h24, 8'hf3, 8'hf0, RESP_OKAY}, '{8'h18, 8'h4f, 8'h40, RESP_OKAY}, '{8'h34, 8'hff, 8'h8f, RESP_OKAY},
		'{8'h40, 8'h55, 8'h00, RESP_SLVERR}};
	logic                  aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic                  arvalid, arready, rvalid, rready, mcu_wait, mcu_freeze, pulse_acc_in, irq;
	logic [AXI_ADDR_W-1:0] awaddr, araddr;
	logic [31:0]           wdata, rdata;
	logic [3:0]            wstrb;
	logic [1:0]            bresp, rresp, rs;
	logic [7:2]            cmp_match, ext_en, ext_val;
	wire logic [7:2]       pout, poe, pin;
	logic [15:0]           main_counter, c0;
	logic [7:0]            rv;
	int                    num_errors, comparisons, cyc;

	tccc_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .ch7_timer_pin_in(pin[7]), .ch6_timer_pin_in(pin[6]),
		.ch5_timer_pin_in(pin[5]), .ch4_timer_pin_in(pin[4]), .ch3_timer_pin_in(pin[3]),
		.ch2_timer_pin_in(pin[2]), .ch7_timer_pin_out(pout[7]), .ch6_timer_pin_out(pout[6]),
		.ch5_timer_pin_out(pout[5]), .ch4_timer_pin_out(pout[4]), .ch3_timer_pin_out(pout[3]),
		.ch2_timer_pin_out(pout[2]), .ch7_timer_pin_oe(poe[7]), .ch6_timer_pin_oe(poe[6]),
		.ch5_timer_pin_oe(poe[5]), .ch4_timer_pin_oe(poe[4]), .ch3_timer_pin_oe(poe[3]),
		.ch2_timer_pin_oe(poe[2]), .cmp_match(cmp_match), .mcu_wait(mcu_wait), .mcu_freeze(mcu_freeze),
		.main_counter(main_counter), .pulse_acc_in(pulse_acc_in), .irq(irq));

	tccc_pin_model u_pins (.aclk(aclk), .pin_out(pout), .pin_oe(poe), .ext_en(ext_en), .ext_val(ext_val),
		.pin_in(pin));

	always #5 aclk = ~aclk;

	task automatic close_out();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			$display("CHECK FAILED run length expected under 5000 seen 5000");
			close_out();
		end
	end

	task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk_val

	task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk_resp

	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [7:2] m, output logic [1:0] r);
		logic aw_ok, w_ok, hit;
		int n;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		hit = 1'b0;
		r = 2'h3;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				aw_ok = 1'b1;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				w_ok = 1'b1;
			end
			if (hit)
				cmp_match <= 6'h00;
			else if (aw_ok && w_ok) begin
				cmp_match <= m;
				hit = 1'b1;
			end
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
		int n;
		d = 8'h00;
		r = 2'h3;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata[7:0];
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask : axi_rd

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [1:0] r;
		axi_wr(a, d, 6'h00, r);
		chk_resp("write resp", RESP_OKAY, r);
	endtask : wr

	task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk_val(n, e, d);
	endtask : rd_chk

	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, mcu_wait, mcu_freeze} = 7'h00;
		{awaddr, araddr, wdata} = '0;
		{cmp_match, ext_en, ext_val} = '0;
		{num_errors, comparisons, cyc} = '0;
		wstrb = 4'hf;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk_val("oe after reset", 6'h00, poe);
		for (int i = 0; i < 16; i++)
			rd_chk("reset value", 8'(i * 4), 8'h00);
		$display("reset test done");
		ext_en[7] <= 1'b1;
		ext_val[7] <= 1'b1;
		for (int i = 0; i < 12 && pulse_acc_in !== 1'b1; i++)
			@(posedge aclk);
		chk_val("accumulator input", 1'b1, pulse_acc_in);
		ext_val[7] <= 1'b0;
		for (int i = 0; i < 12 && pulse_acc_in !== 1'b0; i++)
			@(posedge aclk);
		chk_val("accumulator input", 1'b0, pulse_acc_in);
		$display("accumulator pin test done");
		foreach (ROWS[i]) begin
			axi_wr(ROWS[i].a, ROWS[i].w, 6'h00, rs);
			chk_resp("write resp", ROWS[i].s, rs);
			axi_rd(ROWS[i].a, rv, rs);
			chk_val("read back", ROWS[i].r, rv);
			chk_resp("read resp", ROWS[i].s, rs);
		end
		$display("register table done");
		wr(8'h04, 8'h84);
		chk_val("override pins", 6'h2a, pout);
		chk_val("override oe", 6'h3f, poe);
		rd_chk("flags after force", 8'h38, 8'h00);
		wr(8'h08, 8'h00);
		wr(8'h24, 8'h50);
		repeat (2) @(posedge aclk);
		chk_val("oe own action", 6'h03, poe);
		wr(8'h04, 8'h0c);
		chk_val("forced toggle", 2'b01, pout[3:2]);
		axi_wr(8'h04, 8'h08, 6'h02, rs);
		chk_val("force with match", 2'b11, pout[3:2]);
		rd_chk("flags force with match", 8'h38, 8'h00);
		$display("force test done");
		@(posedge aclk);
		cmp_match <= 6'h01;
		@(posedge aclk);
		cmp_match <= 6'h00;
		repeat (3) @(posedge aclk);
		chk_val("match toggle", 2'b10, pout[3:2]);
		rd_chk("flag on match", 8'h38, 8'h04);
		chk_val("irq masked", 1'b0, irq);
		wr(8'h30, 8'h04);
		repeat (2) @(posedge aclk);
		chk_val("irq raised", 1'b1, irq);
		wr(8'h38, 8'h04);
		repeat (2) @(posedge aclk);
		chk_val("irq cleared", 1'b0, irq);
		rd_chk("flag cleared", 8'h38, 8'h00);
		$display("interrupt test done");
		wr(8'h18, 8'hc0);
		@(posedge aclk);
		c0 = main_counter;
		repeat (10) @(posedge aclk);
		chk_val("counter runs", c0 + 16'h000a, main_counter);
		mcu_wait <= 1'b1;
		repeat (3) @(posedge aclk);
		c0 = main_counter;
		repeat (10) @(posedge aclk);
		chk_val("counter held in wait", c0, main_counter);
		mcu_wait <= 1'b0;
		wr(8'h18, 8'ha0);
		mcu_freeze <= 1'b1;
		repeat (3) @(posedge aclk);
		c0 = main_counter;
		repeat (10) @(posedge aclk);
		chk_val("counter held in freeze", c0, main_counter);
		mcu_freeze <= 1'b0;
		wr(8'h18, 8'h00);
		repeat (2) @(posedge aclk);
		c0 = main_counter;
		repeat (10) @(posedge aclk);
		chk_val("counter stopped", c0, main_counter);
		$display("counter test done");
		wr(8'h00, 8'h00);
		repeat (2) @(posedge aclk);
		chk_val("capture oe", 6'h00, poe);
		wr(8'h28, 8'h40);
		ext_val[7] <= 1'b1;
		repeat (8) @(posedge aclk);
		rd_chk("capture rise flag", 8'h38, 8'h80);
		wr(8'h38, 8'h80);
		rd_chk("capture flag cleared", 8'h38, 8'h00);
		$display("capture mode test done");
		close_out();
	end
endmodule : tccc_tb_top
`default_nettype wire
